// ### hw/tsq_pkg.sv
package tsq_pkg;

  // ------------------------------------------------------------
  // Matrix geometry
  // ------------------------------------------------------------
  localparam int X_LINES   = 8;
  localparam int Y_LINES   = 3;
  localparam int KEYS      = 24;
  localparam int X_W       = 3;
  localparam int Y_W       = 2;
  localparam int KEY_W     = 5;
  localparam logic [X_W-1:0] LAST_X = 3'h7;
  localparam logic [Y_W-1:0] LAST_Y = 2'h2;

  // ------------------------------------------------------------
  // Field widths and timing in clock cycles
  // ------------------------------------------------------------
  localparam int BURST_W   = 8;
  localparam int LIMIT_W   = 8;
  localparam int TIMER_W   = 8;
  localparam int RAMP_W    = 10;
  localparam int DWELL_CYC = 4;
  localparam int LOW_CYC   = 4;
  localparam int CLAMP_CYC = 8;
  localparam int RAMP_MAX_CYC = 800;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [BURST_W-1:0] burst_pulse_count;
    logic [LIMIT_W-1:0] detect_integrator_limit;
  } tsq_key_cfg_t;

  localparam tsq_key_cfg_t CFG_RESET = '{burst_pulse_count: 8'h00,
                                         detect_integrator_limit: 8'h00};

  typedef struct packed {
    logic [KEY_W-1:0]  key;
    logic [RAMP_W-1:0] count;
  } tsq_result_t;

  typedef enum logic [2:0] {
    S_FETCH, S_LOAD, S_HIGH, S_LOW, S_CLAMP, S_RAMP, S_REPORT
  } tsq_state_t;

endpackage

// ### hw/tsq_cfg_mem.sv
`timescale 1ns/100ps
module tsq_cfg_mem #(
  parameter int KEYS_P = tsq_pkg::KEYS
) (
  input  wire logic                  clock,
  input  wire logic                  nrst,
  input  wire logic                  wr_en,
  input  wire logic [tsq_pkg::KEY_W-1:0] wr_key,
  input  wire tsq_pkg::tsq_key_cfg_t wr_data,
  input  wire logic [tsq_pkg::KEY_W-1:0] rd_key,
  output tsq_pkg::tsq_key_cfg_t      rd_data
);
  import tsq_pkg::*;

  if (KEYS_P < 1 || KEYS_P > (1 << KEY_W)) begin : g_bad_keys
    $error("tsq_cfg_mem: key count out of range");
  end

  typedef struct packed {
    tsq_key_cfg_t [KEYS_P-1:0] entry;
    tsq_key_cfg_t              rd;
  } tsq_mem_state_t;

  tsq_mem_state_t s;
  tsq_mem_state_t next_s;

  // Reset clears every entry, so every key starts disabled
  always_comb begin
    next_s = s;
    for (int i = 0; i < KEYS_P; i++) begin
      if (wr_en && (wr_key == KEY_W'(i))) begin
        next_s.entry[i] = wr_data;
      end
    end
    next_s.rd = (32'(rd_key) < KEYS_P) ? s.entry[rd_key] : CFG_RESET;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rd_data = s.rd;

endmodule

// ### hw/tsq_scan_sequencer.sv
`timescale 1ns/100ps
// Contract
// - Keys are numbered 0 to 23 as eight times the receive line plus the drive line.
// - A scan starts at drive 0 on receive 0 and walks drive lines upward per receive line.
// - Each key with a nonzero integrator limit gets a burst whose pulse count is that key's own burst setting.
// - A key's burst is fully finished before any pulse of the next key starts.
// - When a burst ends its charge is converted and handed on as a digital value.
// - Keys whose integrator limit is zero get no burst and are skipped.
// - On every falling drive edge the active receive line is clamped to ground.
// - After the last pulse of a burst the receive line is clamped to start conversion.
// - The count from ramp start to the zero crossing is reported as the measurement.
module tsq_scan_sequencer #(
  parameter int DWELL_P    = tsq_pkg::DWELL_CYC,
  parameter int LOW_P      = tsq_pkg::LOW_CYC,
  parameter int CLAMP_P    = tsq_pkg::CLAMP_CYC,
  parameter int RAMP_MAX_P = tsq_pkg::RAMP_MAX_CYC
) (
  input  wire logic                          clock,
  input  wire logic                          nrst,
  input  wire logic                          cfg_we,
  input  wire logic [tsq_pkg::KEY_W-1:0]     cfg_key,
  input  wire tsq_pkg::tsq_key_cfg_t         cfg_data,
  input  wire logic [tsq_pkg::Y_LINES-1:0]   receive_capacitor_pin_in,
  output logic [tsq_pkg::Y_LINES-1:0]        receive_capacitor_pin_out,
  output logic [tsq_pkg::Y_LINES-1:0]        receive_capacitor_pin_oe,
  output logic [tsq_pkg::X_LINES-1:0]        drive_line,
  output logic                               ramp_enable,
  output logic                               result_valid,
  output tsq_pkg::tsq_result_t               result
);
  import tsq_pkg::*;

  if (DWELL_P < 1 || DWELL_P > 255 || LOW_P < 1 || LOW_P > 255 ||
      CLAMP_P < 1 || CLAMP_P > 255) begin : g_bad_timer
    $error("tsq_scan_sequencer: phase length out of timer range");
  end
  if (RAMP_MAX_P < 1 || RAMP_MAX_P > 999) begin : g_bad_ramp
    $error("tsq_scan_sequencer: ramp limit out of range");
  end

  localparam logic [TIMER_W-1:0] DWELL_T  = TIMER_W'(DWELL_P - 1);
  localparam logic [TIMER_W-1:0] LOW_T    = TIMER_W'(LOW_P - 1);
  localparam logic [TIMER_W-1:0] CLAMP_T  = TIMER_W'(CLAMP_P - 1);
  localparam logic [RAMP_W-1:0]  RAMP_TOP = RAMP_W'(RAMP_MAX_P);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    tsq_state_t          state;
    logic [X_W-1:0]      x;
    logic [Y_W-1:0]      y;
    logic [BURST_W-1:0]  burst;
    logic [BURST_W-1:0]  pulses;
    logic [BURST_W-1:0]  falls;
    logic [TIMER_W-1:0]  timer;
    logic [RAMP_W-1:0]   ramp_cnt;
    logic [X_LINES-1:0]  drive;
    logic [Y_LINES-1:0]  clamp;
    logic [Y_LINES-1:0]  pin_out;
    logic                ramp_en;
    logic                res_valid;
    tsq_result_t         res;
  } tsq_seq_state_t;

  tsq_seq_state_t s;
  tsq_seq_state_t next_s;
  tsq_key_cfg_t   cfg;
  logic           zero_cross;

  tsq_cfg_mem #(
    .KEYS_P (KEYS)
  ) u_cfg_mem (
    .clock   (clock),
    .nrst    (nrst),
    .wr_en   (cfg_we),
    .wr_key  (cfg_key),
    .wr_data (cfg_data),
    .rd_key  ({s.y, s.x}),
    .rd_data (cfg)
  );

  assign zero_cross = receive_capacitor_pin_in[s.y];

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_comb begin
    next_s           = s;
    next_s.res_valid = 1'b0;
    case (s.state)
      S_FETCH: begin
        // Config read is registered, so one cycle passes before it is valid
        next_s.state = S_LOAD;
      end
      S_LOAD: begin
        next_s.burst = cfg.burst_pulse_count;
        next_s.falls = '0;
        if (cfg.detect_integrator_limit == '0) begin
          next_s.state = S_REPORT;
        end else if (cfg.burst_pulse_count == '0) begin
          next_s.state       = S_CLAMP;
          next_s.clamp[s.y]  = 1'b1;
          next_s.timer       = CLAMP_T;
        end else begin
          next_s.pulses      = cfg.burst_pulse_count;
          next_s.state       = S_HIGH;
          next_s.drive[s.x]  = 1'b1;
          next_s.timer       = DWELL_T;
        end
      end
      S_HIGH: begin
        if (s.timer != '0) begin
          next_s.timer = s.timer - 1'b1;
        end else begin
          next_s.state      = S_LOW;
          next_s.drive      = '0;
          next_s.clamp[s.y] = 1'b1;
          next_s.timer      = LOW_T;
          next_s.pulses     = s.pulses - 1'b1;
          next_s.falls      = s.falls + 1'b1;
        end
      end
      S_LOW: begin
        if (s.timer != '0) begin
          next_s.timer = s.timer - 1'b1;
        end else if (s.pulses != '0) begin
          next_s.state      = S_HIGH;
          next_s.clamp      = '0;
          next_s.drive[s.x] = 1'b1;
          next_s.timer      = DWELL_T;
        end else begin
          // Clamp is kept on through into the post-burst phase
          next_s.state = S_CLAMP;
          next_s.timer = CLAMP_T;
        end
      end
      S_CLAMP: begin
        if (s.timer != '0) begin
          next_s.timer = s.timer - 1'b1;
        end else begin
          next_s.state    = S_RAMP;
          next_s.clamp    = '0;
          next_s.ramp_en  = 1'b1;
          next_s.ramp_cnt = '0;
        end
      end
      S_RAMP: begin
        // A missing crossing is cut off at the limit so the scan never hangs
        if (zero_cross || s.ramp_cnt == RAMP_TOP) begin
          next_s.state     = S_REPORT;
          next_s.ramp_en   = 1'b0;
          next_s.res_valid = 1'b1;
          next_s.res.key   = {s.y, s.x};
          next_s.res.count = s.ramp_cnt;
        end else begin
          next_s.ramp_cnt = s.ramp_cnt + 1'b1;
        end
      end
      S_REPORT: begin
        next_s.state = S_FETCH;
        if (s.x == LAST_X && s.y == LAST_Y) begin
          next_s.x = '0;
          next_s.y = '0;
        end else if (s.x == LAST_X) begin
          next_s.x = '0;
          next_s.y = s.y + 1'b1;
        end else begin
          next_s.x = s.x + 1'b1;
        end
      end
      default: begin
        next_s.state = S_FETCH;
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign receive_capacitor_pin_out = s.pin_out;
  assign receive_capacitor_pin_oe  = s.clamp;
  assign drive_line                = s.drive;
  assign ramp_enable               = s.ramp_en;
  assign result_valid              = s.res_valid;
  assign result                    = s.res;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  localparam int RAMP_BOUND  = RAMP_MAX_P + 1;
  localparam int CLAMP_BOUND = CLAMP_P;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence ramp_start_s;
    ##[1:CLAMP_BOUND] s.ramp_en;
  endsequence

  sequence result_s;
    ##[1:RAMP_BOUND] s.res_valid;
  endsequence

  key_number_a: assert property (s.res_valid |-> s.res.key == {s.y, s.x} &&
      s.res.key < KEY_W'(KEYS))
    else $error("result key does not match scan position");

  scan_step_a: assert property (s.state == S_REPORT |=>
      ($past(s.x) == LAST_X && $past(s.y) == LAST_Y) ? (s.x == '0 && s.y == '0) :
      ($past(s.x) == LAST_X) ? (s.x == '0 && s.y == $past(s.y) + 1'b1) :
      (s.x == $past(s.x) + 1'b1 && s.y == $past(s.y)))
    else $error("scan did not step to the next key");

  burst_length_a: assert property ($rose(s.state == S_CLAMP) |-> s.falls == s.burst)
    else $error("burst pulse count differs from key setting");

  no_overlap_a: assert property (s.drive != '0 |-> s.state == S_HIGH && s.drive == (8'h01 << s.x))
    else $error("drive pulse outside its own burst");

  convert_a: assert property ($rose(s.ramp_en) |-> result_s)
    else $error("no result after conversion ramp");

  skip_key_a: assert property (s.state == S_LOAD && cfg.detect_integrator_limit == '0 |=>
      s.state == S_REPORT ##1 s.state == S_FETCH && s.drive == '0 && !s.res_valid)
    else $error("disabled key was not skipped");

  fall_clamp_a: assert property ($past(s.drive) != '0 && s.drive == '0 |->
      s.clamp == (3'h1 << s.y))
    else $error("receive line not clamped on drive fall");

  post_clamp_a: assert property ($rose(s.state == S_CLAMP) |->
      (s.clamp == (3'h1 << s.y) && s.drive == '0) until s.ramp_en)
    else $error("clamp released before ramp");

  clamp_ends_a: assert property ($rose(s.state == S_CLAMP) |-> ramp_start_s)
    else $error("ramp did not start after clamp");

  ramp_count_a: assert property (s.res_valid |-> $past(s.state) == S_RAMP &&
      s.res.count == $past(s.ramp_cnt) && ($past(zero_cross) || $past(s.ramp_cnt) == RAMP_TOP))
    else $error("reported count is not the ramp time");

endmodule

// ### testbench/tsq_matrix_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Electrode matrix with sample capacitors and ramp resistors
// ------------------------------------------------------------
module tsq_matrix_model (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic [7:0] drive_line,
  input  wire logic [2:0] pin_oe,
  input  wire logic       ramp_enable,
  input  wire logic       no_cross,
  output logic [2:0]      pin_in
);
  logic [7:0] prev_drive;
  logic       prev_ramp;
  logic [2:0] line;
  int         pulses;
  int         ramp_cnt;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prev_drive <= '0;
      prev_ramp  <= 1'b0;
      line       <= 3'h1;
      pulses     <= 0;
      ramp_cnt   <= 0;
    end else begin
      prev_drive <= drive_line;
      prev_ramp  <= ramp_enable;
      if (pin_oe != 3'h0) line <= pin_oe;
      if (prev_drive == 8'h00 && drive_line != 8'h00) pulses <= pulses + 1;
      if (prev_ramp && !ramp_enable) pulses <= 0;
      ramp_cnt <= ramp_enable ? ramp_cnt + 1 : 0;
    end
  end

  // Charge grows with each pulse, so the ramp needs longer to cross zero
  // A clamped line reads ground, never a stale crossing
  // Two counts per pulse keep a one-pulse swing above a small touch threshold
  assign pin_in = (ramp_enable && !no_cross && ramp_cnt >= 2 * pulses + 1)
                  ? (line & ~pin_oe) : 3'h0;
endmodule

// ### testbench/tb_touch_matrix_scan_sequencer.sv
`timescale 1ns/100ps
module tb_touch_matrix_scan_sequencer;
  import tsq_pkg::*;
  localparam int RMAX = 20;
  logic         clock;
  logic         nrst;
  logic         cfg_we;
  logic [4:0]   cfg_key;
  tsq_key_cfg_t cfg_data;
  logic [2:0]   pin_in;
  logic [2:0]   pin_oe;
  logic [2:0]   pin_out;
  logic [7:0]   drive_line;
  logic         ramp_enable;
  logic         result_valid;
  logic         no_cross;
  logic         key0_on;
  tsq_result_t  result;
  int           fail_count;
  int           check_count;

  always #4 clock = ~clock;

  tsq_scan_sequencer #(.DWELL_P(2), .LOW_P(2), .CLAMP_P(3), .RAMP_MAX_P(RMAX)) dut (
    .clock(clock), .nrst(nrst), .cfg_we(cfg_we), .cfg_key(cfg_key), .cfg_data(cfg_data),
    .receive_capacitor_pin_in(pin_in), .receive_capacitor_pin_out(pin_out),
    .receive_capacitor_pin_oe(pin_oe), .drive_line(drive_line), .ramp_enable(ramp_enable),
    .result_valid(result_valid), .result(result));

  tsq_matrix_model partner (.clock(clock), .nrst(nrst), .drive_line(drive_line),
    .pin_oe(pin_oe), .ramp_enable(ramp_enable), .no_cross(no_cross), .pin_in(pin_in));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic int burst_of(int k);
    return k % 4;
  endfunction

  function automatic bit on(int k);
    return (k % 3 == 0 && (k != 0 || key0_on)) || k == 23;
  endfunction

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic write_cfg(input int k, input int b, input int l);
    @(posedge clock);
    cfg_we   <= 1'b1;
    cfg_key  <= 5'(k);
    cfg_data <= '{burst_pulse_count: 8'(b), detect_integrator_limit: 8'(l)};
    @(posedge clock);
    cfg_we   <= 1'b0;
  endtask

  // Watches the matrix pins between two results; a timeout ends the run
  task automatic get_result(output tsq_result_t r, output int p, output logic [7:0] xs,
                            output int bad);
    logic [7:0] prev;
    p = 0;
    xs = '0;
    bad = 0;
    prev = drive_line;
    for (int i = 0; i < 3000; i++) begin
      @(negedge clock);
      if (prev == 8'h00 && drive_line != 8'h00) p++;
      if (prev != 8'h00 && drive_line == 8'h00 && pin_oe == 3'h0) bad++;
      // A clamp must pull the receive pin to ground
      if (pin_oe != 3'h0 && pin_out !== 3'h0) bad++;
      xs |= drive_line;
      prev = drive_line;
      if (result_valid === 1'b1) begin
        r = result;
        return;
      end
    end
    fail_count++;
    report_and_stop();
  endtask

  task automatic expect_key(input int k);
    tsq_result_t r;
    int          p;
    int          bad;
    logic [7:0]  xs;
    get_result(r, p, xs, bad);
    check(r.key, k);
    check(p, burst_of(k));
    check(xs, burst_of(k) != 0 ? 8'h01 << (k % 8) : 8'h00);
    check(bad, 0);
    check(r.count, 2 * burst_of(k) + 1);
  endtask

  task automatic sync_to(input int k);
    tsq_result_t r;
    int          p;
    int          bad;
    logic [7:0]  xs;
    r.key = 5'h1f;
    for (int i = 0; i < 40 && r.key != 5'(k); i++) get_result(r, p, xs, bad);
    check(r.key, k);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic test_round();
    for (int k = 0; k < 24; k++) write_cfg(k, on(k) ? burst_of(k) : 5, on(k) ? 3 : 0);
    write_cfg(30, 2, 4);
    sync_to(0);
    for (int k = 3; k < 24; k++) if (on(k)) expect_key(k);
    expect_key(0);
    $display("test_round finished");
  endtask

  task automatic test_timeout();
    tsq_result_t r;
    int          p;
    int          bad;
    logic [7:0]  xs;
    @(posedge clock);
    no_cross <= 1'b1;
    get_result(r, p, xs, bad);
    check(r.count, RMAX);
    @(posedge clock);
    no_cross <= 1'b0;
    $display("test_timeout finished");
  endtask

  task automatic test_skip_wrap();
    key0_on = 1'b0;
    write_cfg(0, 1, 0);
    sync_to(21);
    expect_key(23);
    expect_key(3);
    $display("test_skip_wrap finished");
  endtask

  initial begin
    clock = 1'b0;
    nrst = 1'b0;
    cfg_we = 1'b0;
    cfg_key = '0;
    cfg_data = CFG_RESET;
    no_cross = 1'b0;
    key0_on = 1'b1;
    fail_count = 0;
    check_count = 0;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    test_round();
    test_timeout();
    test_skip_wrap();
    report_and_stop();
  end
endmodule
